// [src/isp_pkg.sv]
// Package: register map, field layout and carrier types of the priority select block
`default_nettype none
package isp_pkg;
    localparam int          NSRC          = 7;
    localparam int          ADDR_W        = 4;
    // Byte offsets on the register bus
    localparam logic [3:0]  PRIO_OFFSET   = 4'h0;
    localparam logic [3:0]  STATUS_OFFSET = 4'h4;
    // Priority register fields
    localparam int          UNUSED_BIT    = 7;
    localparam int          SPI_BIT       = 6;
    localparam int          TMR2_BIT      = 5;
    localparam int          UART_BIT      = 4;
    localparam int          TMR1_BIT      = 3;
    localparam int          EXT1_BIT      = 2;
    localparam int          TMR0_BIT      = 1;
    localparam int          EXT0_BIT      = 0;
    localparam logic [6:0]  PRIO_RESET    = 7'h00;
    localparam logic [7:0]  PRIO_RD_SET   = 8'h80;
    // Status register fields: pending in 6:0, low active 8, high active 9
    localparam int          ST_LO_BIT     = 8;
    localparam int          ST_HI_BIT     = 9;

    // Request handed to the core's vectoring logic
    typedef struct packed {
        logic       valid;
        logic       level;
        logic [2:0] vector;
    } isp_offer_t;

    // Levels currently in service
    typedef struct packed {
        logic hi;
        logic lo;
    } isp_active_t;
endpackage : isp_pkg
`default_nettype wire

// [src/isp_prio_pick.sv]
// Fixed-order picker: lowest set index of a request vector wins
`timescale 1ns/100ps
`default_nettype none
module isp_prio_pick #(
    parameter int N = 7
) (
    input  wire logic [N-1:0] req,
    output logic              found,
    output logic [2:0]        index
);
    // Lowest index first, matching the core's polling order
    function automatic logic [2:0] first_set(input logic [N-1:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : first_set

    // Combinational pick
    always_comb
    begin
        found = |req;
        index = first_set(req);
    end
endmodule : isp_prio_pick
`default_nettype wire

// [src/isp_inservice.sv]
// In-service tracker: one flag per level, set on acknowledge, cleared on return
`timescale 1ns/100ps
`default_nettype none
module isp_inservice (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         take,
    input  wire logic         take_level,
    input  wire logic         ret,
    output isp_pkg::isp_active_t active,
    output isp_pkg::isp_active_t next_active
);
    // Return closes the highest running level; a take in the same cycle wins
    always_comb
    begin
        next_active = active;
        if (ret)
        begin
            if (active.hi)
            begin
                next_active.hi = 1'b0;
            end
            else
            begin
                next_active.lo = 1'b0;
            end
        end
        if (take)
        begin
            if (take_level)
            begin
                next_active.hi = 1'b1;
            end
            else
            begin
                next_active.lo = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            active <= '0;
        end
        else
        begin
            active <= next_active;
        end
    end
endmodule : isp_inservice
`default_nettype wire

// [src/isp_prio_select.sv]
// Interrupt priority select: priority register, level split and offer to the core
//
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module isp_prio_select (
    input  wire logic                         clk,
    input  wire logic                         reset_n,
    input  wire logic [isp_pkg::ADDR_W-1:0]   avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [31:0]                  avs_writedata,
    input  wire logic [3:0]                   avs_byteenable,
    output logic [31:0]                       avs_readdata,
    output logic                              avs_waitrequest,
    input  wire logic [isp_pkg::NSRC-1:0]     irq_req,
    input  wire logic                         irq_ack,
    input  wire logic                         irq_return,
    output isp_pkg::isp_offer_t               offer
);
    logic [6:0]                 prio;
    logic [6:0]                 next_prio;
    logic                       done;
    logic                       next_done;
    logic [31:0]                next_readdata;
    logic [isp_pkg::NSRC-1:0]   req_hi;
    logic [isp_pkg::NSRC-1:0]   req_lo;
    logic                       hi_found;
    logic                       lo_found;
    logic [2:0]                 hi_index;
    logic [2:0]                 lo_index;
    logic                       take;
    isp_pkg::isp_active_t       active;
    isp_pkg::isp_active_t       next_active;
    isp_pkg::isp_offer_t        next_offer;

    // One wait cycle per access; read data is loaded on the first edge, write data on the second
    assign avs_waitrequest = (avs_read | avs_write) & ~done;

    // Bus access and priority register
    always_comb
    begin
        next_done     = (avs_read | avs_write) & ~done;
        next_prio     = prio;
        next_readdata = avs_readdata;
        if (avs_write && done && avs_address == isp_pkg::PRIO_OFFSET && avs_byteenable[0])
        begin
            next_prio = avs_writedata[6:0];
        end
        if (avs_read && !done)
        begin
            unique case (avs_address)
                isp_pkg::PRIO_OFFSET:
                    next_readdata = {24'h000000, isp_pkg::PRIO_RD_SET | {1'b0, prio}};
                isp_pkg::STATUS_OFFSET:
                    next_readdata = {22'h0, active.hi, active.lo, 1'b0, irq_req};
                default:
                    next_readdata = 32'h00000000; // Unmapped reads as zero
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            prio         <= isp_pkg::PRIO_RESET;
            done         <= 1'b0;
            avs_readdata <= 32'h00000000;
        end
        else
        begin
            prio         <= next_prio;
            done         <= next_done;
            avs_readdata <= next_readdata;
        end
    end

    // Level split: a set bit sends its source to the high level
    always_comb
    begin
        req_hi = irq_req & prio;
        req_lo = irq_req & ~prio;
    end

    isp_prio_pick #(
        .N      (isp_pkg::NSRC)
    ) u_pick_hi (
        .req    (req_hi),
        .found  (hi_found),
        .index  (hi_index)
    );

    isp_prio_pick #(
        .N      (isp_pkg::NSRC)
    ) u_pick_lo (
        .req    (req_lo),
        .found  (lo_found),
        .index  (lo_index)
    );

    assign take = offer.valid & irq_ack;

    isp_inservice u_inservice (
        .clk         (clk),
        .reset_n     (reset_n),
        .take        (take),
        .take_level  (offer.level),
        .ret         (irq_return),
        .active      (active),
        .next_active (next_active)
    );

    // Offer built from next in-service state, so a taken offer never lingers
    always_comb
    begin
        next_offer = '0;
        if (hi_found && !next_active.hi)
        begin
            next_offer.valid  = 1'b1;
            next_offer.level  = 1'b1;
            next_offer.vector = hi_index;
        end
        else if (lo_found && !next_active.hi && !next_active.lo)
        begin
            next_offer.valid  = 1'b1;
            next_offer.level  = 1'b0;
            next_offer.vector = lo_index;
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            offer <= '0;
        end
        else
        begin
            offer <= next_offer;
        end
    end

    // Checks next to the logic they guard
    property p_top_bit_one;
        @(posedge clk) disable iff (!reset_n)
        (avs_read && !done && avs_address == isp_pkg::PRIO_OFFSET) |=> avs_readdata[7];
    endproperty
    a_top_bit_one: assert property (p_top_bit_one) else $error("top bit read not one");

    property p_spi_level;
        @(posedge clk) disable iff (!reset_n)
        (offer.valid && offer.vector == 3'h6) |-> offer.level == $past(prio[6]);
    endproperty
    a_spi_level: assert property (p_spi_level) else $error("spi level wrong");

    property p_tmr2_write;
        @(posedge clk) disable iff (!reset_n)
        (avs_write && !avs_waitrequest && avs_address == isp_pkg::PRIO_OFFSET
            && avs_byteenable[0]) |=> prio[5] == $past(avs_writedata[5]);
    endproperty
    a_tmr2_write: assert property (p_tmr2_write) else $error("timer two bit not stored");

    property p_uart_hi;
        @(posedge clk) disable iff (!reset_n)
        (req_hi == 7'h10 && !next_active.hi) |=> offer.valid && offer.level
            && offer.vector == 3'(isp_pkg::UART_BIT);
    endproperty
    a_uart_hi: assert property (p_uart_hi) else $error("uart high not offered");

    property p_tmr1_lo;
        @(posedge clk) disable iff (!reset_n)
        (offer.valid && offer.vector == 3'h3 && !$past(prio[3])) |-> !offer.level;
    endproperty
    a_tmr1_lo: assert property (p_tmr1_lo) else $error("timer one not low");

    property p_ext1_level;
        @(posedge clk) disable iff (!reset_n)
        (offer.valid && offer.vector == 3'h2) |-> offer.level == $past(prio[2]);
    endproperty
    a_ext1_level: assert property (p_ext1_level) else $error("ext one level wrong");

    property p_tmr0_level;
        @(posedge clk) disable iff (!reset_n)
        (offer.valid && offer.vector == 3'(isp_pkg::TMR0_BIT))
            |-> offer.level == $past(prio[isp_pkg::TMR0_BIT]);
    endproperty
    a_tmr0_level: assert property (p_tmr0_level) else $error("timer zero level wrong");

    property p_ext0_lo;
        @(posedge clk) disable iff (!reset_n)
        (irq_req == 7'h01 && !prio[0] && next_active == 2'b00) |=> offer.valid
            && !offer.level && offer.vector == 3'h0;
    endproperty
    a_ext0_lo: assert property (p_ext0_lo) else $error("ext zero low not offered");

    property p_hi_blocks;
        @(posedge clk) disable iff (!reset_n)
        active.hi |-> !offer.valid;
    endproperty
    a_hi_blocks: assert property (p_hi_blocks) else $error("offer during high service");

    property p_lo_only_hi;
        @(posedge clk) disable iff (!reset_n)
        (active.lo && offer.valid) |-> offer.level;
    endproperty
    a_lo_only_hi: assert property (p_lo_only_hi) else $error("low preempted low");

    property p_bus_answer;
        @(posedge clk) disable iff (!reset_n)
        $rose(avs_read | avs_write) |=> !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

    // Whole stored field follows a completed write; bit 7 has no storage
    property p_prio_store;
        @(posedge clk) disable iff (!reset_n)
        (avs_write && !avs_waitrequest && avs_address == isp_pkg::PRIO_OFFSET
            && avs_byteenable[0]) |=> prio == $past(avs_writedata[6:0]);
    endproperty
    a_prio_store: assert property (p_prio_store) else $error("priority write not stored");

    // Read returns the stored bits under a forced top bit
    property p_prio_read;
        @(posedge clk) disable iff (!reset_n)
        (avs_read && !done && avs_address == isp_pkg::PRIO_OFFSET)
            |=> avs_readdata == {24'h000000, 1'b1, $past(prio)};
    endproperty
    a_prio_read: assert property (p_prio_read) else $error("priority read wrong");

    // Refused writes must not disturb the levels already chosen
    property p_write_refused;
        @(posedge clk) disable iff (!reset_n)
        (avs_write && !avs_waitrequest
            && (avs_address != isp_pkg::PRIO_OFFSET || !avs_byteenable[0])) |=> $stable(prio);
    endproperty
    a_write_refused: assert property (p_write_refused) else $error("refused write stored");

    // A lone high request is offered at its own vector
    property p_spi_hi;
        @(posedge clk) disable iff (!reset_n)
        (req_hi == 7'h40 && !next_active.hi) |=> offer.valid && offer.level
            && offer.vector == 3'(isp_pkg::SPI_BIT);
    endproperty
    a_spi_hi: assert property (p_spi_hi) else $error("spi high not offered");

    property p_tmr2_level;
        @(posedge clk) disable iff (!reset_n)
        (offer.valid && offer.vector == 3'(isp_pkg::TMR2_BIT))
            |-> offer.level == $past(prio[isp_pkg::TMR2_BIT]);
    endproperty
    a_tmr2_level: assert property (p_tmr2_level) else $error("timer two level wrong");

    property p_uart_level;
        @(posedge clk) disable iff (!reset_n)
        (offer.valid && offer.vector == 3'(isp_pkg::UART_BIT))
            |-> offer.level == $past(prio[isp_pkg::UART_BIT]);
    endproperty
    a_uart_level: assert property (p_uart_level) else $error("uart level wrong");

    property p_tmr1_hi;
        @(posedge clk) disable iff (!reset_n)
        (req_hi == 7'h08 && !next_active.hi) |=> offer.valid && offer.level
            && offer.vector == 3'(isp_pkg::TMR1_BIT);
    endproperty
    a_tmr1_hi: assert property (p_tmr1_hi) else $error("timer one high not offered");

    property p_ext1_lo;
        @(posedge clk) disable iff (!reset_n)
        (req_hi == 7'h00 && req_lo == 7'h04 && next_active == 2'b00) |=> offer.valid
            && !offer.level && offer.vector == 3'(isp_pkg::EXT1_BIT);
    endproperty
    a_ext1_lo: assert property (p_ext1_lo) else $error("ext one low not offered");

    property p_tmr0_hi;
        @(posedge clk) disable iff (!reset_n)
        (req_hi == 7'h02 && !next_active.hi) |=> offer.valid && offer.level
            && offer.vector == 3'(isp_pkg::TMR0_BIT);
    endproperty
    a_tmr0_hi: assert property (p_tmr0_hi) else $error("timer zero high not offered");

    property p_ext0_level;
        @(posedge clk) disable iff (!reset_n)
        (offer.valid && offer.vector == 3'(isp_pkg::EXT0_BIT))
            |-> offer.level == $past(prio[isp_pkg::EXT0_BIT]);
    endproperty
    a_ext0_level: assert property (p_ext0_level) else $error("ext zero level wrong");

    // Pending high work is offered even while low work runs
    property p_hi_preempts;
        @(posedge clk) disable iff (!reset_n)
        ((|req_hi) && !next_active.hi) |=> offer.valid && offer.level;
    endproperty
    a_hi_preempts: assert property (p_hi_preempts) else $error("high not offered");

    property p_lo_waits;
        @(posedge clk) disable iff (!reset_n)
        ((|req_lo) && !(|req_hi) && next_active == 2'b00) |=> offer.valid && !offer.level;
    endproperty
    a_lo_waits: assert property (p_lo_waits) else $error("idle low not offered");

    // Status shows the levels in service as they stood at the read
    property p_status_read;
        @(posedge clk) disable iff (!reset_n)
        (avs_read && !done && avs_address == isp_pkg::STATUS_OFFSET)
            |=> avs_readdata[isp_pkg::ST_HI_BIT] == $past(active.hi)
            && avs_readdata[isp_pkg::ST_LO_BIT] == $past(active.lo);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status levels wrong");

    c_preempt: cover property (@(posedge clk) disable iff (!reset_n)
        active.lo && take && offer.level);
    c_prio_write: cover property (@(posedge clk) disable iff (!reset_n)
        avs_write && !avs_waitrequest && avs_address == isp_pkg::PRIO_OFFSET);
    c_status_read: cover property (@(posedge clk) disable iff (!reset_n)
        avs_read && !avs_waitrequest && avs_address == isp_pkg::STATUS_OFFSET);
    c_nested_return: cover property (@(posedge clk) disable iff (!reset_n)
        active == 2'b11 ##[1:20] irq_return);
    c_lane_refused: cover property (@(posedge clk) disable iff (!reset_n)
        avs_write && !avs_waitrequest && !avs_byteenable[0]);
endmodule : isp_prio_select
`default_nettype wire

// [tb/isp_core_model.sv]
// Core-side model: accepts the offers of the priority select block
`timescale 1ns/100ps
`default_nettype none
module isp_core_model (
    input  wire logic                clk,
    input  wire logic                reset_n,
    input  wire logic                ack_en,
    input  wire isp_pkg::isp_offer_t offer,
    output logic                     irq_ack
);
    // One pulse per offer; holding ack_en low models a slow core
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            irq_ack <= 1'b0;
        else
            irq_ack <= ack_en && offer.valid && !irq_ack;
    end
endmodule : isp_core_model
`default_nettype wire

// [tb/isp_prio_select_test.sv]
// Self-checking bench for the interrupt priority select block
`timescale 1ns/100ps
`default_nettype none
module isp_prio_select_test;
    logic                clk = 1'b0;
    logic                reset_n = 1'b0;
    logic [3:0]          avs_address = 4'h0;
    logic                avs_read = 1'b0;
    logic                avs_write = 1'b0;
    logic [31:0]         avs_writedata = 32'h0;
    logic [3:0]          avs_byteenable = 4'hf;
    logic [31:0]         avs_readdata;
    logic                avs_waitrequest;
    logic [6:0]          irq_req = 7'h00;
    logic                irq_ack;
    logic                irq_return = 1'b0;
    logic                ack_en = 1'b0;
    isp_pkg::isp_offer_t offer;
    int                  fail_count = 0;
    int                  check_count = 0;
    logic [31:0]         rd;

    // 125 MHz clock
    always #4 clk = ~clk;

    isp_prio_select isp_prio_select_inst (
        .clk(clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq_req(irq_req), .irq_ack(irq_ack),
        .irq_return(irq_return), .offer(offer)
    );

    isp_core_model isp_core_model_inst (
        .clk(clk), .reset_n(reset_n), .ack_en(ack_en), .offer(offer), .irq_ack(irq_ack)
    );

    task automatic close_out;
        if (fail_count == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    // Holds the request up to the edge that sees waitrequest low, takes data there
    task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0)
        begin
            fail_count++;
            close_out();
        end
    endtask : bus

    task automatic set_req(input logic [6:0] v);
        @(posedge clk);
        irq_req <= v;
    endtask : set_req

    // Two edges for the registered offer, then look between edges
    task automatic settle;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask : settle

    // Lets the core model take exactly one offer
    task automatic take_one;
        int n;
        n = 0;
        @(posedge clk);
        ack_en <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (irq_ack !== 1'b1 && n < 20);
        ack_en <= 1'b0;
        if (irq_ack !== 1'b1)
        begin
            fail_count++;
            close_out();
        end
    endtask : take_one

    task automatic pulse_return;
        @(posedge clk);
        irq_return <= 1'b1;
        @(posedge clk);
        irq_return <= 1'b0;
    endtask : pulse_return

    // Top bit reads one whatever is written; unmapped place reads zero
    task automatic reg_scenario;
        bus(4'h0, 1'b0, 32'h0, rd);
        check(rd, 32'h80);
        bus(4'h0, 1'b1, 32'h7f, rd);
        bus(4'h0, 1'b0, 32'h0, rd);
        check(rd, 32'hff);
        bus(4'h0, 1'b1, 32'h80, rd);
        bus(4'h0, 1'b0, 32'h0, rd);
        check(rd, 32'h80);
        bus(4'h8, 1'b1, 32'hff, rd);
        bus(4'h8, 1'b0, 32'h0, rd);
        check(rd, 32'h0);
        avs_byteenable <= 4'he;
        bus(4'h0, 1'b1, 32'h7f, rd);
        avs_byteenable <= 4'hf;
        bus(4'h0, 1'b0, 32'h0, rd);
        check(rd, 32'h80);
    endtask : reg_scenario

    // Each bit alone lifts its source to high level, cleared it drops it low
    task automatic level_scenario;
        for (int i = 0; i < 7; i++)
        begin
            bus(4'h0, 1'b1, 32'h1 << i, rd);
            bus(4'h0, 1'b0, 32'h0, rd);
            check(rd, 32'h80 | (32'h1 << i));
            set_req(7'h7f);
            settle();
            check(32'(offer), {27'h0, 2'b11, i[2:0]});
            bus(4'h0, 1'b1, 32'h7f & ~(32'h1 << i), rd);
            set_req(7'h1 << i);
            settle();
            check(32'(offer), {27'h0, 2'b10, i[2:0]});
        end
        set_req(7'h00);
    endtask : level_scenario

    // High preempts low service; a low request preempts neither high nor low service
    task automatic preempt_scenario;
        bus(4'h0, 1'b1, 32'h10, rd);
        set_req(7'h01);
        settle();
        check(32'(offer), 32'h10);
        take_one();
        settle();
        check(32'(offer.valid), 32'h0);
        set_req(7'h11);
        settle();
        check(32'(offer), 32'h1c);
        take_one();
        set_req(7'h40);
        settle();
        check(32'(offer.valid), 32'h0);
        bus(4'h4, 1'b0, 32'h0, rd);
        check(rd, 32'h340);
        pulse_return();
        settle();
        check(32'(offer.valid), 32'h0);
        pulse_return();
        settle();
        check(32'(offer), 32'h16);
        set_req(7'h00);
    endtask : preempt_scenario

    // Mid-run reset drops stored levels and the level in service
    task automatic reset_scenario;
        bus(4'h0, 1'b1, 32'h7f, rd);
        set_req(7'h01);
        take_one();
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        reset_n <= 1'b1;
        bus(4'h4, 1'b0, 32'h0, rd);
        check(rd, 32'h1);
        bus(4'h0, 1'b0, 32'h0, rd);
        check(rd, 32'h80);
        settle();
        check(32'(offer), 32'h10);
        set_req(7'h00);
    endtask : reset_scenario

    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        reg_scenario();
        level_scenario();
        preempt_scenario();
        reset_scenario();
        close_out();
    end
endmodule : isp_prio_select_test
`default_nettype wire
